//--- dv/line_tx.sv
// Purpose: far-end line source, one channel byte first bit first
// Assumes: one bit a cycle
// Notes: idle line toggles so a stale bit never looks valid
`timescale 1ns/100ps
module line_tx (
   input wire aclk,
   input wire go,
   input wire [7:0] word,
   output reg bit_o,
   output reg stb,
   output reg last
);
reg [7:0] sh_r;
reg [3:0] n_r;
initial {n_r, stb, last, bit_o} = 7'h00;
always @(posedge aclk) begin
   stb <= n_r != 4'h0;
   last <= n_r == 4'h1;
   if (go) begin
      sh_r <= word;
      n_r <= 4'h8;
   end else if (n_r != 4'h0) begin
      bit_o <= sh_r[7];
      sh_r <= {sh_r[6:0], 1'b0};
      n_r <= n_r - 4'h1;
   end else begin
      bit_o <= ~bit_o;
   end
end
endmodule

//--- dv/rx_overhead_checker.sv
// Purpose: bus checks at the register group ports
// Assumes: one aclk domain
// Notes: bound to the design top
`timescale 1ns/100ps
module rx_overhead_checker #(
   parameter [7:0] FW_REV = 8'h00
) (
   input wire aclk,
   input wire aresetn,
   input wire e1_mode,
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire s_axi_bvalid,
   input wire s_axi_bready
);
// =====
// helpers
wire rd_go = s_axi_arvalid && s_axi_arready;
wire [9:0] ix = s_axi_araddr[11:2];
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
// =====
// assertions
a_read_next: assert property (rd_go |=> s_axi_rvalid) else $error("no read answer");
a_rdata_pad: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
   else $error("upper bits set");
a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
   s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
   else $error("write answer dropped");
a_unmapped_err: assert property (rd_go && (ix < 10'h060 || ix > 10'h066) |=>
   s_axi_rresp == 2'h2 && s_axi_rdata == 32'h00000000) else $error("unmapped read");
a_rev_view: assert property (rd_go && ix == 10'h061 |=>
   s_axi_rdata[7:0] == ($past(e1_mode) ? FW_REV : 8'h00)) else $error("revision");
a_code_pad: assert property (rd_go && ix == 10'h063 && !e1_mode |=>
   s_axi_rdata[7:6] == 2'h0) else $error("code pad");
c_unmapped: cover property (rd_go && ix > 10'h066);
c_rev: cover property (rd_go && ix == 10'h061 && e1_mode);
c_write: cover property (s_axi_bvalid && s_axi_bready);
c_read_stall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule
bind rx_overhead_status_regs rx_overhead_checker #(.FW_REV(FW_REV)) chk_u (.aclk, .aresetn,
   .e1_mode, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready);

//--- dv/testbench.sv
// Purpose: self-checking bench for the overhead register group
// Assumes: line source feeds both serial captures
// Notes: all reads over AXI4-Lite
`timescale 1ns/100ps
module testbench;
localparam [7:0] FW = 8'h5A; // arbitrary revision value
logic aclk = 1'b0, aresetn = 1'b0, e1_mode = 1'b0, d4_mode = 1'b0, crc4_enable = 1'b0;
logic multiframe_boundary = 1'b0, crc_search_timeout = 1'b0, crc_multiframe_sync = 1'b0;
logic bit_code_valid = 1'b0, loop_carrier_update = 1'b0, tx_go = 1'b0, lbit, lstb, llast;
logic align_frame_stb = 1'b0, non_align_frame_stb = 1'b0, ta, tw;
logic [2:0] flags = 3'h0;
logic [5:0] bit_code_field = 6'h00;
logic [23:0] loop_carrier_word = 24'h000000;
logic [7:0] ts0_byte = 8'h00, tx_word = 8'h00;
logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
logic [1:0] s_axi_bresp, s_axi_rresp;
logic [31:0] s_axi_rdata;
int num_errors = 0, n_checks = 0;
always #5 aclk = ~aclk;
line_tx far_u (.aclk, .go(tx_go), .word(tx_word), .bit_o(lbit), .stb(lstb), .last(llast));
rx_overhead_status_regs #(.FW_REV(FW)) dut_u (.aclk, .aresetn, .e1_mode, .d4_mode,
   .crc4_enable, .ds0_bit(lbit), .ds0_bit_stb(lstb), .ds0_byte_end(llast),
   .data_link_bit(lbit), .data_link_stb(lstb), .data_link_byte_end(llast),
   .multiframe_boundary, .crc_search_timeout, .crc_multiframe_sync,
   .crc_multiframe_search_active(flags[2]), .signaling_multiframe_search_active(flags[1]),
   .frame_align_search_active(flags[0]), .bit_code_valid, .bit_code_field,
   .loop_carrier_update, .loop_carrier_word, .ts0_byte, .align_frame_stb,
   .non_align_frame_stb, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wdata(32'hFFFFFFFF), .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
// =====
// shared tasks
task chk(input string nm, input [31:0] e, input [31:0] g);
   n_checks++;
   if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
   end
endtask
function [1:0] resp_of(input [9:0] ix);
   return (ix >= 10'h060 && ix <= 10'h066) ? 2'h0 : 2'h2;
endfunction
task rc(input [9:0] ix, input [7:0] e, input int stall = 0);
   s_axi_araddr <= {ix, 2'h0};
   s_axi_arvalid <= 1'b1;
   // a nonzero stall leaves the answer waiting so the hold checks are reached
   s_axi_rready <= (stall == 0);
   do @(posedge aclk); while (!s_axi_arready);
   s_axi_arvalid <= 1'b0;
   repeat (stall) @(posedge aclk);
   s_axi_rready <= 1'b1;
   do @(posedge aclk); while (!s_axi_rvalid);
   chk($sformatf("rdata %h", ix), {24'h000000, e}, s_axi_rdata);
   chk("rresp", {30'h0, resp_of(ix)}, {30'h0, s_axi_rresp});
   s_axi_rready <= 1'b0;
   @(posedge aclk);
endtask
task wc(input [9:0] ix, input int stall = 0);
   {ta, tw} = 2'h0;
   s_axi_awaddr <= {ix, 2'h0};
   {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
   s_axi_bready <= (stall == 0);
   do begin
      @(posedge aclk);
      ta = ta | s_axi_awready;
      tw = tw | s_axi_wready;
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
   end while (!(ta && tw));
   repeat (stall) @(posedge aclk);
   s_axi_bready <= 1'b1;
   do @(posedge aclk); while (!s_axi_bvalid);
   chk("bresp", {30'h0, resp_of(ix)}, {30'h0, s_axi_bresp});
   s_axi_bready <= 1'b0;
   @(posedge aclk);
endtask
task send(input [7:0] w);
   tx_word <= w;
   tx_go <= 1'b1;
   @(posedge aclk);
   tx_go <= 1'b0;
   repeat (12) @(posedge aclk);
endtask
task tick(input int n);
   repeat (n) begin
      crc_search_timeout <= 1'b1;
      @(posedge aclk);
      crc_search_timeout <= 1'b0;
      @(posedge aclk);
   end
   @(posedge aclk);
endtask
// =====
// scenarios
task t_reset;
   for (int m = 0; m < 2; m++) begin
      e1_mode <= m[0];
      @(posedge aclk);
      for (int i = 'h5F; i <= 'h67; i++) rc(i[9:0], (m == 1 && i == 'h61) ? FW : 8'h00);
   end
   $display("reset values done");
endtask
task t_serial;
   e1_mode <= 1'b0;
   send(8'hB4);
   rc(10'h060, 8'hB4);
   rc(10'h062, 8'h2D);
   d4_mode <= 1'b1;
   send(8'hC6);
   rc(10'h062, 8'h2D);
   multiframe_boundary <= 1'b1;
   @(posedge aclk);
   multiframe_boundary <= 1'b0;
   @(posedge aclk);
   rc(10'h062, 8'h18);
   rc(10'h060, 8'hC6);
   d4_mode <= 1'b0;
   $display("serial capture done");
endtask
task t_codes;
   bit_code_field <= 6'h2B;
   bit_code_valid <= 1'b1;
   loop_carrier_word <= 24'hC3A51E;
   loop_carrier_update <= 1'b1;
   @(posedge aclk);
   {bit_code_valid, loop_carrier_update} <= 2'h0;
   bit_code_field <= 6'h15;
   @(posedge aclk);
   rc(10'h063, 8'h2B);
   wc(10'h063);
   wc(10'h070, 2);
   rc(10'h063, 8'h2B, 2);
   for (int i = 0; i < 3; i++) rc(10'h064 + i[9:0], loop_carrier_word[8*i+:8]);
   $display("codes done");
endtask
task t_e1;
   e1_mode <= 1'b1;
   ts0_byte <= 8'h9B;
   align_frame_stb <= 1'b1;
   @(posedge aclk);
   align_frame_stb <= 1'b0;
   ts0_byte <= 8'h5F;
   non_align_frame_stb <= 1'b1;
   @(posedge aclk);
   non_align_frame_stb <= 1'b0;
   @(posedge aclk);
   rc(10'h064, 8'h9B);
   rc(10'h065, 8'h5F);
   $display("timeslot zero done");
endtask
task t_count;
   crc4_enable <= 1'b1;
   flags <= 3'h5;
   tick(6);
   rc(10'h062, 8'h15);
   flags <= 3'h2;
   repeat (2) @(posedge aclk);
   rc(10'h062, 8'h12);
   crc_multiframe_sync <= 1'b1;
   @(posedge aclk);
   crc_multiframe_sync <= 1'b0;
   @(posedge aclk);
   rc(10'h062, 8'h02);
   tick(66);
   rc(10'h062, 8'hFA);
   // acting as host: the hunt ran past its time limit, so give up on it
   crc4_enable <= 1'b0;
   @(posedge aclk);
   crc4_enable <= 1'b1;
   @(posedge aclk);
   rc(10'h062, 8'h02);
   $display("search counter done");
endtask
task conclude;
   $display("checks %0d errors %0d", n_checks, num_errors);
   if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
   else $display("RESULT: FAIL");
   $finish;
endtask
initial begin
   repeat (16) @(posedge aclk);
   aresetn <= 1'b1;
   @(posedge aclk);
   t_reset;
   t_serial;
   t_codes;
   t_e1;
   t_count;
   conclude;
end
initial begin
   repeat (5000) @(posedge aclk);
   num_errors++;
   conclude;
end
endmodule

//--- shared/rx_overhead_regs.vh
// Purpose: constants for the receive overhead and sync status register group
// Assumes: 32-bit AXI4-Lite bus, one register per aligned word
// Notes: register indices; byte address is four times the index
`ifndef RX_OVERHEAD_REGS_VH
`define RX_OVERHEAD_REGS_VH

// ==========================================================
// register indices
`define IDX_DS0_MONITOR 10'h060
`define IDX_FW_REVISION 10'h061
`define IDX_DATA_LINK 10'h062
`define IDX_BIT_CODE 10'h063
`define IDX_LINK_1 10'h064
`define IDX_LINK_2 10'h065
`define IDX_LINK_3 10'h066

// ==========================================================
// address decode
`define ADDR_W 12
`define IDX_HI 11
`define IDX_LO 2

// ==========================================================
// reset values and field limits
`define BYTE_RESET 8'h00
`define CNT_RESET 6'h00
`define CNT_MAX 6'h3F
`define CNT_ONE 6'h01
`define FW_REV_DEFAULT 8'h00
`define UPPER_ZERO 24'h000000
`define BOC_PAD 2'h0
`define FLAGS_RESET 3'h0

// ==========================================================
// bus response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- verilog/rx_overhead_status_regs.v
// Purpose: receive overhead capture and E1 sync search status registers
// Assumes: framer core delivers bits, strobes and search flags on aclk
// Notes: every register is read-only; writes answer OKAY in the mapped range, SLVERR elsewhere, and change nothing
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "rx_overhead_regs.vh"

module rx_overhead_status_regs #(
   parameter [7:0] FW_REV = `FW_REV_DEFAULT
) (
   input wire aclk,
   input wire aresetn,
   input wire e1_mode,
   input wire d4_mode,
   input wire crc4_enable,
   input wire ds0_bit,
   input wire ds0_bit_stb,
   input wire ds0_byte_end,
   input wire data_link_bit,
   input wire data_link_stb,
   input wire data_link_byte_end,
   input wire multiframe_boundary,
   input wire crc_search_timeout,
   input wire crc_multiframe_sync,
   input wire crc_multiframe_search_active,
   input wire signaling_multiframe_search_active,
   input wire frame_align_search_active,
   input wire bit_code_valid,
   input wire [5:0] bit_code_field,
   input wire loop_carrier_update,
   input wire [23:0] loop_carrier_word,
   input wire [7:0] ts0_byte,
   input wire align_frame_stb,
   input wire non_align_frame_stb,
   input wire [`ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [`ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);

   // ==========================================================
   // capture state
   reg [7:0] ds0_shift_r;
   reg [7:0] ds0_monitor_byte_r;
   reg [7:0] link_shift_r;
   reg [7:0] data_link_bits_r;
   reg [5:0] crc_sync_search_count_r;
   reg [5:0] crc_sync_search_count_nxt;
   reg [2:0] search_flags_r;
   reg [5:0] bit_code_r;
   reg [23:0] loop_carrier_r;
   reg [7:0] align_frame_r;
   reg [7:0] non_align_frame_r;
   wire [7:0] sync_status;

   // ==========================================================
   // DS0 monitor: bits arrive first-to-last, so shift toward the MSB
   always @(posedge aclk) begin
      if (!aresetn) begin
         ds0_shift_r <= `BYTE_RESET;
         ds0_monitor_byte_r <= `BYTE_RESET;
      end else begin
         if (ds0_bit_stb) begin
            ds0_shift_r <= {ds0_shift_r[6:0], ds0_bit};
         end
         // the last bit may land in the same cycle as the end marker
         if (ds0_byte_end) begin
            if (ds0_bit_stb) begin
               ds0_monitor_byte_r <= {ds0_shift_r[6:0], ds0_bit};
            end else begin
               ds0_monitor_byte_r <= ds0_shift_r;
            end
         end
      end
   end

   // ==========================================================
   // data link: first bit received ends up as the LSB, so shift right
   wire [7:0] link_shift_next = {data_link_bit, link_shift_r[7:1]};
   wire [7:0] link_view = data_link_stb ? link_shift_next : link_shift_r;

   always @(posedge aclk) begin
      if (!aresetn) begin
         link_shift_r <= `BYTE_RESET;
         data_link_bits_r <= `BYTE_RESET;
      end else begin
         if (data_link_stb) begin
            link_shift_r <= link_shift_next;
         end
         if (d4_mode) begin
            // six framing bits sit in the top of the shifter after six shifts
            if (multiframe_boundary) begin
               data_link_bits_r <= {`BOC_PAD, link_view[7:2]};
            end
         end else if (data_link_byte_end) begin
            data_link_bits_r <= link_view;
         end
      end
   end

   // ==========================================================
   // CRC-4 sync search counter
   always @* begin
      crc_sync_search_count_nxt = crc_sync_search_count_r;
      if (!crc4_enable) begin
         crc_sync_search_count_nxt = `CNT_RESET;
      end else if (crc_multiframe_sync) begin
         crc_sync_search_count_nxt = `CNT_RESET;
      end else if (crc_search_timeout && crc_sync_search_count_r != `CNT_MAX) begin
         // hold at the top so a long hunt is never mistaken for a short one
         crc_sync_search_count_nxt = crc_sync_search_count_r + `CNT_ONE;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         crc_sync_search_count_r <= `CNT_RESET;
         search_flags_r <= `FLAGS_RESET;
      end else begin
         crc_sync_search_count_r <= crc_sync_search_count_nxt;
         // flags follow the synchronizer every cycle, nothing is latched
         search_flags_r <= {crc_multiframe_search_active,
                            signaling_multiframe_search_active,
                            frame_align_search_active};
      end
   end

   // counter bit 1 is dropped so five visible bits still span the long hunt
   assign sync_status = {crc_sync_search_count_r[5:2], crc_sync_search_count_r[0],
                         search_flags_r};

   // ==========================================================
   // T1 code and loop carrier link, E1 timeslot 0 capture
   always @(posedge aclk) begin
      if (!aresetn) begin
         bit_code_r <= `CNT_RESET;
         loop_carrier_r <= `UPPER_ZERO;
         align_frame_r <= `BYTE_RESET;
         non_align_frame_r <= `BYTE_RESET;
      end else begin
         if (bit_code_valid) begin
            bit_code_r <= bit_code_field;
         end
         if (loop_carrier_update) begin
            loop_carrier_r <= loop_carrier_word;
         end
         if (align_frame_stb) begin
            align_frame_r <= ts0_byte;
         end
         if (non_align_frame_stb) begin
            non_align_frame_r <= ts0_byte;
         end
      end
   end

   // ==========================================================
   // read multiplexer
   wire [9:0] rd_idx = s_axi_araddr[`IDX_HI:`IDX_LO];
   reg [7:0] rd_byte;
   reg rd_hit;

   always @* begin
      rd_byte = `BYTE_RESET;
      rd_hit = 1'b1;
      case (rd_idx)
         `IDX_DS0_MONITOR: rd_byte = ds0_monitor_byte_r;
         `IDX_FW_REVISION: rd_byte = e1_mode ? FW_REV : `BYTE_RESET;
         `IDX_DATA_LINK: rd_byte = e1_mode ? sync_status : data_link_bits_r;
         `IDX_BIT_CODE: rd_byte = e1_mode ? `BYTE_RESET : {`BOC_PAD, bit_code_r};
         `IDX_LINK_1: rd_byte = e1_mode ? align_frame_r : loop_carrier_r[7:0];
         `IDX_LINK_2: rd_byte = e1_mode ? non_align_frame_r : loop_carrier_r[15:8];
         // the E1 view of this word lives in another block
         `IDX_LINK_3: rd_byte = e1_mode ? `BYTE_RESET : loop_carrier_r[23:16];
         default: rd_hit = 1'b0;
      endcase
   end

   // ==========================================================
   // AXI4-Lite read channel: one read in flight, answered the cycle after the take
   localparam [1:0] RD_IDLE = 2'b01;
   localparam [1:0] RD_RESP = 2'b10;
   reg [1:0] rd_state_r;
   reg [1:0] rd_state_nxt;
   wire ar_take = s_axi_arvalid && s_axi_arready;

   always @* begin
      rd_state_nxt = rd_state_r;
      case (rd_state_r)
         RD_IDLE: begin
            if (ar_take) begin
               rd_state_nxt = RD_RESP;
            end
         end
         RD_RESP: begin
            if (s_axi_rready) begin
               rd_state_nxt = RD_IDLE;
            end
         end
         default: begin
            rd_state_nxt = RD_IDLE;
         end
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_r <= RD_IDLE;
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= {`UPPER_ZERO, `BYTE_RESET};
         s_axi_rresp <= `RESP_OKAY;
      end else begin
         rd_state_r <= rd_state_nxt;
         if (rd_state_r == RD_RESP) begin
            if (s_axi_rready) begin
               s_axi_rvalid <= 1'b0;
               s_axi_arready <= 1'b1;
            end
         end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {`UPPER_ZERO, rd_byte};
            s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
         end
      end
   end

   // ==========================================================
   // AXI4-Lite write channel: decoded only to choose the response
   // address and data may land in either order, so each has a waiting state
   localparam [4:0] WR_IDLE = 5'b00001;
   localparam [4:0] WR_ADDR = 5'b00010;
   localparam [4:0] WR_DATA = 5'b00100;
   localparam [4:0] WR_BOTH = 5'b01000;
   localparam [4:0] WR_RESP = 5'b10000;
   reg [4:0] wr_state_r;
   reg [4:0] wr_state_nxt;
   reg aw_hit_r;
   wire [9:0] wr_idx = s_axi_awaddr[`IDX_HI:`IDX_LO];
   wire wr_hit = (wr_idx >= `IDX_DS0_MONITOR) && (wr_idx <= `IDX_LINK_3);
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;

   always @* begin
      wr_state_nxt = wr_state_r;
      case (wr_state_r)
         WR_IDLE: begin
            if (aw_take && w_take) begin
               wr_state_nxt = WR_BOTH;
            end else if (aw_take) begin
               wr_state_nxt = WR_ADDR;
            end else if (w_take) begin
               wr_state_nxt = WR_DATA;
            end
         end
         WR_ADDR: begin
            if (w_take) begin
               wr_state_nxt = WR_BOTH;
            end
         end
         WR_DATA: begin
            if (aw_take) begin
               wr_state_nxt = WR_BOTH;
            end
         end
         WR_BOTH: begin
            wr_state_nxt = WR_RESP;
         end
         WR_RESP: begin
            if (s_axi_bready) begin
               wr_state_nxt = WR_IDLE;
            end
         end
         default: begin
            wr_state_nxt = WR_IDLE;
         end
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_r <= WR_IDLE;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         aw_hit_r <= 1'b0;
      end else begin
         wr_state_r <= wr_state_nxt;
         if (aw_take) begin
            s_axi_awready <= 1'b0;
            aw_hit_r <= wr_hit;
         end
         if (w_take) begin
            s_axi_wready <= 1'b0;
         end
         if (wr_state_r == WR_BOTH) begin
            // contents never change on a write
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= aw_hit_r ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (wr_state_r == WR_RESP && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

endmodule
